// file: burst_sram_port.sv
// Purpose: two-port two-word-burst ddr sram, device side
// Assumes: K_CLK is the positive input clock, its fall is the negative clock rise
// Notes:   read and echo outputs are ddr, built from a rise flop xor a fall flop
//
// Behaviour
// - pll on: first word 2.5 cycles after load
// - pll off: legacy single cycle read latency
// - transactions start on positive clock rise only
// - read select low loads read address
// - two 18-bit words, low word first
// - two arrays, one per burst word
// - deselected read: finish, then tristate outputs
// - write select low latches first data word
// - fall latches address, second word; commit on next rise
// - deselected write port ignores its inputs
// - byte selects gate each written byte
// - read and write ports run independently
// - same address returns newest, forwarded data
// - selects sampled on rise; no cross-disturbance
// - impedance update every 1024 clock cycles
// - free-running echo clocks, both phases
// - pll on: valid output leads data by half cycle; pll off: valid rises on the fall before the first word
// - pll locks after 100 us stable clock
// - power up deselected, outputs tristated
// - all selects deasserted leaves word unchanged
`timescale 1ns/1ps
`include "burst_sram_defs.svh"

module burst_sram_port
	import burst_sram_pkg::*;
#(
	parameter int                          ADDR_W      = `BSR_ADDR_W,
	parameter logic [`BSR_LOCK_CNT_W-1:0] LOCK_CYCLES = `BSR_LOCK_CNT_W'(`BSR_LOCK_CYCLES)
)
(
	input  wire logic                   CLK,
	input  wire logic                   RSTN,
	input  wire logic                   K_CLK,
	input  wire logic [ADDR_W-1:0]      ADDR,
	input  wire logic [`BSR_WORD_W-1:0] WRITE_DATA,
	input  wire logic [1:0]             BYTE_WRITE_SELECT_N,
	input  wire logic                   READ_PORT_SELECT_N,
	input  wire logic                   WRITE_PORT_SELECT_N,
	input  wire logic                   PLL_DISABLE_N,
	output logic      [`BSR_WORD_W-1:0] READ_DATA,
	output logic                        READ_DATA_OE,
	output logic                        READ_DATA_VALID,
	output logic                        ECHO_CLOCK,
	output logic                        ECHO_CLOCK_N,
	output logic                        PLL_LOCK,
	output logic                        IMPEDANCE_UPDATE
);

	sram_array_if #(.ADDR_W(ADDR_W)) arr ();

	logic                       rst_s1_q;   // CLK reset release, stage 1
	logic                       rst_n_q;    // CLK domain reset
	logic                       lrst_s1_q;  // link reset release, stage 1
	logic                       lrst_n_q;   // link domain reset
	logic                       pd_s1_q;    // pll strap sync into link
	logic                       pd_s2_q;
	lat_mode_t                  mode;       // read latency mode
	logic [2:0]                 rd_v_q;     // read pipeline valid
	pair_t                      rd_d0_q;    // read pipeline data
	pair_t                      rd_d1_q;
	pair_t                      rd_d2_q;
	pair_t                      rd_word;    // array data with forwarding
	logic                       fwd_hit;    // read hits committing write
	logic                       wstart_q;   // write started on last rise
	logic [`BSR_WORD_W-1:0]     wlo_q;      // first write word
	logic [1:0]                 wbl_q;      // byte selects of first word
	logic                       wcap_q;     // address and second word held
	logic [ADDR_W-1:0]          waddr_q;    // write address
	logic [`BSR_WORD_W-1:0]     whi_q;      // second write word
	logic [1:0]                 wbh_q;      // byte selects of second word
	logic [`BSR_DDR_W-1:0]      want_pos;   // output value for the high phase
	logic [`BSR_DDR_W-1:0]      want_neg;   // output value for the low phase
	logic [`BSR_DDR_W-1:0]      ddr_p_q;    // rise half of ddr pair
	logic [`BSR_DDR_W-1:0]      ddr_n_q;    // fall half of ddr pair
	logic [`BSR_IMP_CNT_W-1:0]  imp_cnt_q;  // impedance period counter
	logic                       imp_tgl_q;  // toggles once per period
	logic                       it_s1_q;    // toggle sync into CLK
	logic                       it_s2_q;
	logic                       it_s3_q;
	logic                       pl_s1_q;    // pll strap sync into CLK
	logic                       pl_s2_q;
	logic [`BSR_LOCK_CNT_W-1:0] lock_cnt_q; // stable clock counter

	// reset release in CLK domain
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_s1_q <= 1'h0;
			rst_n_q  <= 1'h0;
		end
		else
		begin
			rst_s1_q <= 1'h1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// reset release in link domain; needs two K rises after RSTN rises
	always_ff @(posedge K_CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			lrst_s1_q <= 1'h0;
			lrst_n_q  <= 1'h0;
		end
		else
		begin
			lrst_s1_q <= 1'h1;
			lrst_n_q  <= lrst_s1_q;
		end
	end

	// pll strap is static, so a plain level sync is enough
	always_ff @(posedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
		begin
			pd_s1_q <= 1'h0;
			pd_s2_q <= 1'h0;
		end
		else
		begin
			pd_s1_q <= PLL_DISABLE_N;
			pd_s2_q <= pd_s1_q;
		end
	end

	// strap high: extended latency; low: legacy
	assign mode = pd_s2_q ? LAT_EXTENDED : LAT_LEGACY;

	// array hookup; read address comes straight from the pins
	assign arr.rd_addr = ADDR;
	assign arr.wr_en   = wcap_q;
	assign arr.wr_addr = waddr_q;
	assign arr.wr_data = {whi_q, wlo_q};
	assign arr.wr_be   = ~{wbh_q, wbl_q};

	// a write committing on this rise is merged in, bytes as enabled
	assign fwd_hit = wcap_q && (waddr_q == ADDR);
	assign rd_word = fwd_hit ? byte_merge(arr.rd_data, arr.wr_data, arr.wr_be) : arr.rd_data;

	// read pipeline; selects only looked at on the rise
	always_ff @(posedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
		begin
			rd_v_q  <= 3'h0;
			rd_d0_q <= '0;
			rd_d1_q <= '0;
			rd_d2_q <= '0;
		end
		else
		begin
			// high select starts no read but lets older ones drain
			rd_v_q <= {rd_v_q[1:0], !READ_PORT_SELECT_N};
			if (!READ_PORT_SELECT_N)
				rd_d0_q <= rd_word;
			rd_d1_q <= rd_d0_q;
			rd_d2_q <= rd_d1_q;
		end
	end

	// write first half: data word and byte selects on the rise
	always_ff @(posedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
		begin
			wstart_q <= 1'h0;
			wlo_q    <= '0;
			wbl_q    <= 2'h3;
		end
		else
		begin
			wstart_q <= !WRITE_PORT_SELECT_N;
			// deselected: inputs are not even stored
			if (!WRITE_PORT_SELECT_N)
			begin
				wlo_q <= WRITE_DATA;
				wbl_q <= BYTE_WRITE_SELECT_N;
			end
		end
	end

	// write second half on the negative clock rise
	always_ff @(negedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
		begin
			wcap_q  <= 1'h0;
			waddr_q <= '0;
			whi_q   <= '0;
			wbh_q   <= 2'h3;
		end
		else
		begin
			wcap_q <= wstart_q; // commit happens on the next rise
			if (wstart_q)
			begin
				waddr_q <= ADDR;
				whi_q   <= WRITE_DATA;
				wbh_q   <= BYTE_WRITE_SELECT_N;
			end
		end
	end

	// output schedule; fields: valid, oe, echo, echo_n, data
	always_comb
	begin
		if (mode == LAT_EXTENDED)
		begin
			// rise at t+2 raises valid, rise at t+3 shows the high word
			want_pos = {rd_v_q[1], rd_v_q[2], 1'h1, 1'h0, rd_d2_q[2*`BSR_WORD_W-1:`BSR_WORD_W]};
			// fall at t+2 shows the low word
			want_neg = {rd_v_q[2], rd_v_q[2], 1'h0, 1'h1, rd_d2_q[`BSR_WORD_W-1:0]};
		end
		else
		begin
			// legacy: low word at t+1 rise, high word on the following fall
			want_pos = {rd_v_q[0], rd_v_q[0], 1'h1, 1'h0, rd_d0_q[`BSR_WORD_W-1:0]};
			want_neg = {rd_v_q[0], rd_v_q[1], 1'h0, 1'h1, rd_d1_q[2*`BSR_WORD_W-1:`BSR_WORD_W]};
		end
	end

	// ddr pair: xor of the halves avoids a mux on the clock
	always_ff @(posedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
			ddr_p_q <= '0;
		else
			ddr_p_q <= want_pos ^ ddr_n_q;
	end

	always_ff @(negedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
			ddr_n_q <= '0;
		else
			ddr_n_q <= want_neg ^ ddr_p_q;
	end

	// all-zero during reset: outputs tristated, echo clocks low
	assign {READ_DATA_VALID, READ_DATA_OE, ECHO_CLOCK, ECHO_CLOCK_N, READ_DATA} = ddr_p_q ^ ddr_n_q;

	// impedance period counted in input clock cycles
	always_ff @(posedge K_CLK or negedge lrst_n_q)
	begin
		if (!lrst_n_q)
		begin
			imp_cnt_q <= '0;
			imp_tgl_q <= 1'h0;
		end
		else
		begin
			imp_cnt_q <= imp_cnt_q + `BSR_IMP_CNT_W'(1);
			if (imp_cnt_q == `BSR_IMP_CNT_W'(`BSR_IMP_PERIOD - 1))
				imp_tgl_q <= !imp_tgl_q;
		end
	end

	// toggle crossing into CLK; one pulse per period
	always_ff @(posedge CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			it_s1_q          <= 1'h0;
			it_s2_q          <= 1'h0;
			it_s3_q          <= 1'h0;
			IMPEDANCE_UPDATE <= 1'h0;
		end
		else
		begin
			it_s1_q          <= imp_tgl_q;
			it_s2_q          <= it_s1_q;
			it_s3_q          <= it_s2_q;
			IMPEDANCE_UPDATE <= it_s2_q ^ it_s3_q;
		end
	end

	// lock timer; restarts whenever the pll is switched off
	always_ff @(posedge CLK or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			pl_s1_q    <= 1'h0;
			pl_s2_q    <= 1'h0;
			lock_cnt_q <= '0;
			PLL_LOCK   <= 1'h0;
		end
		else
		begin
			pl_s1_q <= PLL_DISABLE_N;
			pl_s2_q <= pl_s1_q;
			if (!pl_s2_q)
				lock_cnt_q <= '0;
			else if (lock_cnt_q != LOCK_CYCLES)
				lock_cnt_q <= lock_cnt_q + `BSR_LOCK_CNT_W'(1);
			// limitation: CLK stands in for a stable input clock
			PLL_LOCK <= pl_s2_q && (lock_cnt_q == LOCK_CYCLES);
		end
	end

	sram_pair_array #(.ADDR_W(ADDR_W)) u_array
	(
		.clk (K_CLK),
		.ifc (arr.mem)
	);

	// low word phase of an extended read shows oe on the third rise
	property p_ext_latency;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		(mode == LAT_EXTENDED && !READ_PORT_SELECT_N) |-> ##3 READ_DATA_OE;
	endproperty
	a_ext_latency: assert property (p_ext_latency) else $error("extended read data late");

	property p_leg_latency;
		@(negedge K_CLK) disable iff (!lrst_n_q)
		(mode == LAT_LEGACY && rd_v_q[0] && $rose(rd_v_q[0])) |=> (READ_DATA_OE && READ_DATA == $past(rd_d0_q[`BSR_WORD_W-1:0]));
	endproperty
	a_leg_latency: assert property (p_leg_latency) else $error("legacy read data wrong");

	property p_idle_tristate;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		(!rd_v_q[1] && !rd_v_q[2]) |-> !READ_DATA_OE;
	endproperty
	a_idle_tristate: assert property (p_idle_tristate) else $error("outputs driven while idle");

	property p_write_commit;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		!WRITE_PORT_SELECT_N |=> (arr.wr_en && arr.wr_data[`BSR_WORD_W-1:0] == $past(WRITE_DATA));
	endproperty
	a_write_commit: assert property (p_write_commit) else $error("write not committed");

	property p_write_ignore;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		WRITE_PORT_SELECT_N |=> !arr.wr_en;
	endproperty
	a_write_ignore: assert property (p_write_ignore) else $error("deselected write committed");

	property p_no_bytes;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		(!WRITE_PORT_SELECT_N && BYTE_WRITE_SELECT_N == 2'h3) |=> (arr.wr_be[1:0] == 2'h0);
	endproperty
	a_no_bytes: assert property (p_no_bytes) else $error("masked byte written");

	// sampled on the rise, the echo pair still shows the low phase
	property p_echo;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		!ECHO_CLOCK && ECHO_CLOCK_N;
	endproperty
	a_echo: assert property (p_echo) else $error("echo clock not in phase");

	// sampled on the fall, the high phase; first fall after release skipped
	property p_echo_fall;
		@(negedge K_CLK) disable iff (!lrst_n_q)
		$past(lrst_n_q) |-> (ECHO_CLOCK && !ECHO_CLOCK_N);
	endproperty
	a_echo_fall: assert property (p_echo_fall) else $error("echo clock high phase wrong");

	property p_valid_lead;
		@(negedge K_CLK) disable iff (!lrst_n_q)
		(mode == LAT_EXTENDED && $rose(rd_v_q[0])) |-> ##2 READ_DATA_VALID;
	endproperty
	a_valid_lead: assert property (p_valid_lead) else $error("valid not ahead of data");

	property p_lock;
		@(posedge CLK) disable iff (!rst_n_q)
		$rose(PLL_LOCK) |-> ($past(lock_cnt_q) == LOCK_CYCLES && pl_s2_q);
	endproperty
	a_lock: assert property (p_lock) else $error("lock reported early");

	property p_imp;
		@(posedge K_CLK) disable iff (!lrst_n_q)
		(imp_cnt_q == `BSR_IMP_CNT_W'(`BSR_IMP_PERIOD - 1)) |=> (imp_tgl_q != $past(imp_tgl_q));
	endproperty
	a_imp: assert property (p_imp) else $error("impedance period missed");

endmodule // burst_sram_port

// file: burst_sram_defs.svh
// Purpose: named constants shared by the burst sram port and its array
// Assumes: included by bare name; definitions only
// Notes:   lock count is derived from the lock time and the CLK period
`ifndef BURST_SRAM_DEFS_SVH
`define BURST_SRAM_DEFS_SVH

`define BSR_WORD_W        18
`define BSR_BYTE_W        9
`define BSR_BYTES         4
`define BSR_ADDR_W        21
`define BSR_CLK_PERIOD_NS 40
`define BSR_LOCK_TIME_NS  100000
// least time: round up to whole CLK cycles
`define BSR_LOCK_CYCLES   ((`BSR_LOCK_TIME_NS + `BSR_CLK_PERIOD_NS - 1) / `BSR_CLK_PERIOD_NS)
`define BSR_LOCK_CNT_W    12
`define BSR_IMP_PERIOD    1024
`define BSR_IMP_CNT_W     10
`define BSR_DDR_W         22

`endif

// file: burst_sram_pkg.sv
// Purpose: types and helpers for the burst sram port
// Assumes: burst_sram_defs.svh holds the numbers
// Notes:   byte_merge is used by the array write and by read forwarding
`include "burst_sram_defs.svh"

package burst_sram_pkg;

	// read latency modes, one-hot
	typedef enum logic [1:0]
	{
		LAT_LEGACY   = 2'h1,
		LAT_EXTENDED = 2'h2
	} lat_mode_t;

	typedef logic [2*`BSR_WORD_W-1:0] pair_t;   // burst pair, low word in low bits
	typedef logic [`BSR_BYTES-1:0]    byte_en_t; // one enable per 9-bit byte

	// replace the enabled bytes of old_v by those of new_v
	function automatic pair_t byte_merge(pair_t old_v, pair_t new_v, byte_en_t be);
		pair_t res;
		res = old_v;
		for (int i = 0; i < `BSR_BYTES; i++)
		begin
			if (be[i])
				res[i*`BSR_BYTE_W +: `BSR_BYTE_W] = new_v[i*`BSR_BYTE_W +: `BSR_BYTE_W];
		end
		return res;
	endfunction

endpackage

// file: sram_array_if.sv
// Purpose: carrier between the port logic and the storage array
// Assumes: write on the link clock rise, read is combinational
// Notes:   ctrl side is the port logic, mem side is the array
`timescale 1ns/1ps
`include "burst_sram_defs.svh"

interface sram_array_if #(parameter int ADDR_W = `BSR_ADDR_W);
	import burst_sram_pkg::*;

	logic              wr_en;   // commit one burst pair
	logic [ADDR_W-1:0] wr_addr; // pair address
	pair_t             wr_data; // pair to write
	byte_en_t          wr_be;   // byte enables, high = write
	logic [ADDR_W-1:0] rd_addr; // read pair address
	pair_t             rd_data; // stored pair at rd_addr

	modport ctrl (output wr_en, output wr_addr, output wr_data, output wr_be,
		output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input wr_be,
		input rd_addr, output rd_data);
endinterface

// file: sram_pair_array.sv
// Purpose: storage as two arrays, one per burst word
// Assumes: wr_* stable around the link clock rise
// Notes:   no reset; contents are undefined until written
`timescale 1ns/1ps
`include "burst_sram_defs.svh"

module sram_pair_array
	import burst_sram_pkg::*;
#(
	parameter int ADDR_W = `BSR_ADDR_W
)
(
	input wire logic clk,
	sram_array_if.mem ifc
);

	// low burst word and high burst word live apart
	logic [`BSR_WORD_W-1:0] mem_lo [0:(1<<ADDR_W)-1];
	logic [`BSR_WORD_W-1:0] mem_hi [0:(1<<ADDR_W)-1];
	pair_t                  cur;     // current pair at the write address
	pair_t                  merged;  // pair after byte enables

	// masked bytes keep their old contents
	always_comb
	begin
		cur    = {mem_hi[ifc.wr_addr], mem_lo[ifc.wr_addr]};
		merged = byte_merge(cur, ifc.wr_data, ifc.wr_be);
	end

	// commit both words of the pair together
	always_ff @(posedge clk)
	begin
		if (ifc.wr_en)
		begin
			mem_lo[ifc.wr_addr] <= merged[`BSR_WORD_W-1:0];
			mem_hi[ifc.wr_addr] <= merged[2*`BSR_WORD_W-1:`BSR_WORD_W];
		end
	end

	// asynchronous read; forwarding is done by the port logic
	assign ifc.rd_data = {mem_hi[ifc.rd_addr], mem_lo[ifc.rd_addr]};

endmodule // sram_pair_array

// file: sram_ctrl_model.sv
// Purpose: memory controller stand-in for the burst sram port
// Assumes: k is the free-running positive input clock
// Notes:   released address and data lines show inverted patterns, never the last value
`timescale 1ns/1ps

module sram_ctrl_model
	import burst_sram_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              k,
	input  wire logic              ext,
	input  wire logic [17:0]       dq,
	input  wire logic              vld,
	input  wire logic              oe,
	output logic      [ADDR_W-1:0] addr,
	output logic      [17:0]       wdata,
	output logic      [1:0]        bws_n,
	output logic                   rps_n,
	output logic                   wps_n
);
	// idle at time zero: both ports deselected
	initial
	begin
		addr  = '0;
		wdata = 18'h00000;
		bws_n = 2'h3;
		rps_n = 1'b1;
		wps_n = 1'b1;
	end

	// words sampled mid-half so edge skew cannot flip the result
	task automatic cap(output logic v, output pair_t q, output logic oe_end);
		if (ext)
		begin
			repeat (2) @(posedge k);
			#12 v = vld;
			@(negedge k);
			#12 q[17:0] = dq;
			@(posedge k);
			#12 q[35:18] = dq;
		end
		else
		begin
			@(negedge k);
			#12 v = vld;
			@(posedge k);
			#12 q[17:0] = dq;
			@(negedge k);
			#12 q[35:18] = dq;
		end
		@(negedge k);
		#12 oe_end = oe;
	endtask

	// one read burst; select held for exactly one rise
	task automatic rd(input logic [ADDR_W-1:0] a, output logic v, output pair_t q,
		output logic oe_end);
		@(posedge k);
		rps_n <= 1'b0;
		addr  <= a;
		@(posedge k);
		rps_n <= 1'b1;
		addr  <= ~a;
		cap(v, q, oe_end);
	endtask

	// one write burst; optional read of the same place one rise later
	task automatic wr(input logic [ADDR_W-1:0] a, input pair_t d, input logic [3:0] be_n,
		input logic rd_next, output logic v, output pair_t q, output logic oe_end);
		@(posedge k);
		wps_n <= 1'b0;
		wdata <= d[17:0];
		bws_n <= be_n[1:0];
		@(posedge k);
		wps_n <= 1'b1;
		addr  <= a;
		wdata <= d[35:18];
		bws_n <= be_n[3:2];
		rps_n <= ~rd_next;
		@(negedge k);
		wdata <= ~d[35:18];
		bws_n <= 2'h3;
		// write address released unless the read still needs it
		if (!rd_next)
			addr <= ~a;
		else
		begin
			@(posedge k);
			rps_n <= 1'b1;
			addr  <= ~a;
			cap(v, q, oe_end);
		end
	endtask
endmodule // sram_ctrl_model

// file: two_port_ddr_burst_sram_interface_tb_top.sv
// Purpose: self-checking bench for the burst sram port
// Assumes: short lock count and 8-bit address for run time
// Notes:   expected pairs come from a local shadow, not the design
`timescale 1ns/1ps
`include "burst_sram_defs.svh"

module two_port_ddr_burst_sram_interface_tb_top
	import burst_sram_pkg::*;
;
	localparam int          AW     = 8;
	localparam logic [11:0] LOCK_N = 12'h010; // shortened lock count

	logic          clk   = 1'b0; // system clock
	logic          rstn  = 1'b0; // reset, active low
	logic          k_clk = 1'b0; // link clock
	logic          ext   = 1'b0; // pll strap, also tells the model the mode
	logic          k_stop = 1'b0; // holds the link clock high while set
	logic [AW-1:0] addr;
	logic [17:0]   wdata;
	logic [1:0]    bws_n;
	logic          rps_n;
	logic          wps_n;
	logic [17:0]   dq;
	logic          oe;
	logic          vld;
	logic          eck;
	logic          eck_n;
	logic          lock;
	logic          imp;
	pair_t         shadow [0:255]; // expected array contents
	int            err_total = 0;
	int            tests_run = 0;
	int            kcnt      = 0;  // link rises since start
	int            last      = 0;  // link count at last impedance pulse
	int            gap       = 0;  // link rises between pulses
	int            pulses    = 0;

	// clocks in unrelated phase
	always #20 clk = ~clk;
	initial
	begin
		#7;
		forever #24 if (!k_stop) k_clk = ~k_clk;
	end

	// impedance pulse spacing measured in link rises
	always @(posedge k_clk)
		kcnt <= kcnt + 1;
	always @(posedge clk)
	begin
		if (imp === 1'b1)
		begin
			gap    <= kcnt - last;
			last   <= kcnt;
			pulses <= pulses + 1;
		end
	end

	burst_sram_port #(.ADDR_W(AW), .LOCK_CYCLES(LOCK_N)) i_burst_sram_port
	(
		.CLK                 (clk),
		.RSTN                (rstn),
		.K_CLK               (k_clk),
		.ADDR                (addr),
		.WRITE_DATA          (wdata),
		.BYTE_WRITE_SELECT_N (bws_n),
		.READ_PORT_SELECT_N  (rps_n),
		.WRITE_PORT_SELECT_N (wps_n),
		.PLL_DISABLE_N       (ext),
		.READ_DATA           (dq),
		.READ_DATA_OE        (oe),
		.READ_DATA_VALID     (vld),
		.ECHO_CLOCK          (eck),
		.ECHO_CLOCK_N        (eck_n),
		.PLL_LOCK            (lock),
		.IMPEDANCE_UPDATE    (imp)
	);

	sram_ctrl_model #(.ADDR_W(AW)) i_sram_ctrl_model
	(
		.k     (k_clk),
		.ext   (ext),
		.dq    (dq),
		.vld   (vld),
		.oe    (oe),
		.addr  (addr),
		.wdata (wdata),
		.bws_n (bws_n),
		.rps_n (rps_n),
		.wps_n (wps_n)
	);

	// one comparison, case equality so an unknown only matches an unknown
	task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// active-low byte enables: a high bit keeps the stored byte
	function automatic pair_t merge(pair_t o, pair_t n, logic [3:0] be_n);
		for (int i = 0; i < 4; i++)
			if (!be_n[i])
				o[i*9 +: 9] = n[i*9 +: 9];
		return o;
	endfunction

	task automatic do_wr(input logic [7:0] a, input pair_t d, input logic [3:0] be_n);
		logic  v;
		pair_t q;
		logic  oe_end;
		i_sram_ctrl_model.wr(a, d, be_n, 1'b0, v, q, oe_end);
		shadow[a] = merge(shadow[a], d, be_n);
	endtask

	task automatic do_rd(input logic [7:0] a);
		logic  v;
		pair_t q;
		logic  oe_end;
		i_sram_ctrl_model.rd(a, v, q, oe_end);
		chk("valid", 36'(v), 36'h1);
		chk("read pair", q, shadow[a]);
		chk("oe after", 36'(oe_end), 36'h0);
	endtask

	task automatic t_reset();
		#12;
		chk("oe idle", 36'(oe), 36'h0);
		chk("valid idle", 36'(vld), 36'h0);
		chk("lock off", 36'(lock), 36'h0);
		$display("test reset done");
	endtask

	// echo phases and quiet outputs while no port is selected
	task automatic t_echo();
		repeat (4)
		begin
			@(posedge k_clk);
			#12;
			chk("echo rise", {34'h0, eck, eck_n}, 36'h2);
			@(negedge k_clk);
			#12;
			chk("echo fall", {34'h0, eck, eck_n}, 36'h1);
			chk("oe nop", 36'(oe), 36'h0);
			chk("valid nop", 36'(vld), 36'h0);
		end
		$display("test echo done");
	endtask

	// lock must wait its count, and only with the pll on
	task automatic t_mode(input logic m);
		@(posedge clk);
		ext <= m;
		repeat (12) @(posedge clk);
		#1;
		chk("lock early", 36'(lock), 36'h0);
		repeat (20) @(posedge clk);
		#1;
		chk("lock", 36'(lock), 36'(m));
		$display("test mode done");
	endtask

	task automatic t_rw(input pair_t x);
		do_wr(8'h05, 36'h1_2345_6789 ^ x, 4'h0);
		do_wr(8'hFF, 36'hA_BCDE_F012 ^ x, 4'h0);
		do_wr(8'h00, 36'h5_5AA5_5AA5 ^ x, 4'h0);
		do_rd(8'h05);
		do_rd(8'hFF);
		do_rd(8'h00);
		$display("test read write done");
	endtask

	// each byte enable alone, then none at all
	task automatic t_bytes();
		logic [3:0] pat [5] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
		do_wr(8'h33, 36'h0_0000_0000, 4'h0);
		foreach (pat[i])
		begin
			do_wr(8'h33, {4{9'(9'h155 + i)}}, pat[i]);
			do_rd(8'h33);
		end
		$display("test bytes done");
	endtask

	// read one rise after a partial write to the same pair
	task automatic t_forward();
		logic  v;
		pair_t q;
		logic  oe_end;
		do_wr(8'h44, 36'h1_1111_1111, 4'h0);
		i_sram_ctrl_model.wr(8'h44, 36'h2_2222_2222, 4'h9, 1'b1, v, q, oe_end);
		shadow[8'h44] = merge(shadow[8'h44], 36'h2_2222_2222, 4'h9);
		chk("forward valid", 36'(v), 36'h1);
		chk("forward pair", q, shadow[8'h44]);
		do_rd(8'h44);
		$display("test forward done");
	endtask

	// link clock stopped high between transfers, then a read again
	task automatic t_stop();
		@(posedge k_clk);
		k_stop = 1'b1;
		#100;
		k_stop = 1'b0;
		do_rd(8'h05);
		$display("test clock stop done");
	endtask

	task automatic t_imp();
		int n;
		n = 0;
		while (pulses < 2 && n < 3000)
		begin
			@(posedge k_clk);
			n++;
		end
		chk("impedance pulses", 36'(pulses >= 2), 36'h1);
		chk("impedance gap", 36'(gap >= 1023 && gap <= 1025), 36'h1);
		$display("test impedance done");
	endtask

	// hang guard, well past the impedance wait
	initial
	begin
		#400000;
		err_total++;
		$display("mismatch watchdog expected finish seen timeout");
		end_of_test();
	end

	// main sequence, both latency modes
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (10) @(posedge k_clk);
		t_reset();
		t_echo();
		for (int m = 0; m < 2; m++)
		begin
			t_mode(m[0]);
			t_rw({36{m[0]}});
			t_bytes();
			t_forward();
		end
		t_stop();
		t_imp();
		end_of_test();
	end
endmodule // two_port_ddr_burst_sram_interface_tb_top
